// [pkg/odc_consts.svh]
// Constants of the octal driver serial control block: field positions, widths, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ODC_CONSTS_SVH
`define ODC_CONSTS_SVH

`define ODC_WORD_W 16
`define ODC_DRV_N 8
`define ODC_PAIR_N 4
`define ODC_PIN_N 4
`define ODC_CNT_W 4
`define ODC_FIFO_DEPTH 8
`define ODC_CMD_EN_LO 0
`define ODC_CMD_OL_LO 8
`define ODC_ST_TW 0
`define ODC_ST_DRV_LO 1
`define ODC_ST_PIN_LO 9
`define ODC_ST_SUPPLY 15
`define ODC_CMD_RESET 16'h0000
`define ODC_STATUS_RESET 16'h0000
`define ODC_SYNC_W 29

`endif

// [pkg/odc_pkg.sv]
// Types shared by the octal driver serial control block.
// Assumes odc_consts.svh is on the include path.
`include "odc_consts.svh"

package odc_pkg;
    typedef logic [`ODC_WORD_W-1:0] odc_word_t;
    typedef logic [`ODC_DRV_N-1:0] odc_drv_t;
    typedef logic [`ODC_PIN_N-1:0] odc_pin_t;
    typedef enum logic [2:0] {
        ODC_IDLE = 3'b001,
        ODC_FRAME = 3'b010,
        ODC_CHECK = 3'b100
    } odc_state_t;
endpackage

// [pkg/odc_stream_if.sv]
// Valid/ready word stream between the frame checker and the command FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface odc_stream_if #(parameter int W = 16) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport producer(output valid, output data, input ready);
    modport consumer(input valid, input data, output ready);
endinterface

// [rtl/odc_fifo.sv]
// Synchronous FIFO for received command words.
// Assumes DEPTH is a power of two and a single clock for both sides.
`timescale 1ns/1ps

module odc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    odc_stream_if.consumer wr,
    odc_stream_if.producer rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, next_wp, rp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////////////
    assign wr.ready = (cnt != FULL_CNT);
    assign rd.valid = (cnt != '0);
    assign rd.data = mem[rp];

    always_comb begin
        push = wr.valid && wr.ready;
        pop = rd.valid && rd.ready;
        next_wp = push ? wp + 1'b1 : wp;
        next_rp = pop ? rp + 1'b1 : rp;
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = cnt + 1'b1;
        end else if (pop && !push) begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else if (clk_en) begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    // Storage carries no reset; only pointers define what is valid
    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem[wp] <= wr.data;
        end
    end
endmodule

// [rtl/odc_spi_ctrl.sv]
// Serial command and status interface of an eight channel power driver.
// Assumes a host that stops serial_clock outside frames and raw fault levels from analogue.
//
// Function
// - 16-bit words, LSB first, both directions
// - Command bits 0-7 switch drivers 1-8
// - Command bits 8-15 enable open-load detection
// - Status bits 1-8 faults, bit 0 warning
// - Bit 15 supply fault, 13-14 zero
// - Status bits 9-12 mirror parallel pins
// - Capture pin levels on overcurrent or shutdown
// - Disabled driver reports only enabled open load
// - Overcurrent latched until frame disables driver
// - Shutdown latched until cool and pair disabled
// - Accept command only for multiples of 16
// - Bit counter armed by select, counts edges
// - Warning bit shown at select fall
// - Channels 5-8 OR serial and pin control
// - Enable pin or reset clears latched faults
`timescale 1ns/1ps
`include "odc_consts.svh"

module odc_spi_ctrl import odc_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic [`ODC_PIN_N-1:0] parallel_drive_input,
    input wire logic enable_pin,
    input wire logic thermal_warning_raw,
    input wire logic [`ODC_PAIR_N-1:0] over_temp_raw,
    input wire logic [`ODC_DRV_N-1:0] over_current_raw,
    input wire logic [`ODC_DRV_N-1:0] open_load_raw,
    input wire logic supply_fault_raw,
    output logic [`ODC_DRV_N-1:0] driver_gate,
    output logic [`ODC_DRV_N-1:0] open_load_enable,
    output logic frame_dropped
);

    // Channels 5-8 may also be driven from the parallel pins
    function automatic odc_drv_t drive_req(input odc_word_t cmd, input odc_pin_t pins);
        drive_req = cmd[`ODC_CMD_EN_LO +: `ODC_DRV_N] | {pins, 4'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain, clocked by the host's serial clock

    odc_word_t rx_q, next_rx;
    logic [`ODC_CNT_W-1:0] cnt_q, next_cnt;
    logic tog_q, next_tog;
    logic rx_started, tx_started;
    odc_word_t tx_q, next_tx;
    odc_word_t status_hold, next_status_hold;

    // Chip select high clears the arming flag, so the first edge restarts the count
    always_ff @(posedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            rx_started <= 1'b0;
        end else begin
            rx_started <= 1'b1;
        end
    end

    always_comb begin
        next_rx = {serial_in, rx_q[`ODC_WORD_W-1:1]};
        next_cnt = rx_started ? cnt_q + 1'b1 : `ODC_CNT_W'(1);
        next_tog = rx_started ? tog_q : ~tog_q;
    end

    // Count and word survive the frame end: the system side reads them while the link is still
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            rx_q <= `ODC_CMD_RESET;
            cnt_q <= '0;
            tog_q <= 1'b0;
        end else begin
            rx_q <= next_rx;
            cnt_q <= next_cnt;
            tog_q <= next_tog;
        end
    end

    // Received bits follow the status word out, which lets devices chain
    always_comb begin
        if (tx_started) begin
            next_tx = {rx_q[`ODC_WORD_W-1], tx_q[`ODC_WORD_W-1:1]};
        end else begin
            next_tx = {rx_q[`ODC_WORD_W-1], status_hold[`ODC_WORD_W-1:1]};
        end
    end

    always_ff @(negedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            tx_started <= 1'b0;
            tx_q <= `ODC_STATUS_RESET;
        end else begin
            tx_started <= 1'b1;
            tx_q <= next_tx;
        end
    end

    // Before any clock edge the frozen warning bit is on the line at once
    assign serial_out = tx_started ? tx_q[0] : status_hold[`ODC_ST_TW];
    assign serial_out_oe = ~chip_select_n;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers into the system domain

    logic [`ODC_SYNC_W-1:0] sync_a, sync_b;
    odc_pin_t pin_s;
    logic enable_s, tw_s, sf_s, cs_n_s, tog_s;
    logic [`ODC_PAIR_N-1:0] ot_s;
    odc_drv_t oc_s, ol_s;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync_a <= '0;
            sync_b <= '0;
        end else if (clk_en) begin
            sync_a <= {parallel_drive_input, enable_pin, thermal_warning_raw, over_temp_raw,
                       over_current_raw, open_load_raw, supply_fault_raw, chip_select_n, tog_q};
            sync_b <= sync_a;
        end
    end

    assign {pin_s, enable_s, tw_s, ot_s, oc_s, ol_s, sf_s, cs_n_s, tog_s} = sync_b;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame checker and command queue

    odc_state_t state, next_state;
    logic tog_seen, next_tog_seen;
    logic dropped, next_dropped;
    logic frame_good;
    odc_stream_if #(.W(`ODC_WORD_W)) fifo_in ();
    odc_stream_if #(.W(`ODC_WORD_W)) fifo_out ();

    odc_fifo #(.WIDTH(`ODC_WORD_W), .DEPTH(`ODC_FIFO_DEPTH)) u_fifo (
        .clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .wr(fifo_in),
        .rd(fifo_out)
    );

    // Count and word are quiet once select is seen high, so reading them here is safe
    always_comb begin
        next_state = state;
        next_tog_seen = tog_seen;
        next_dropped = 1'b0;
        frame_good = (tog_s != tog_seen) && (cnt_q == '0);
        fifo_in.valid = 1'b0;
        fifo_in.data = rx_q;
        case (state)
            ODC_IDLE: begin
                if (!cs_n_s) begin
                    next_state = ODC_FRAME;
                end
            end
            ODC_FRAME: begin
                if (cs_n_s) begin
                    next_state = ODC_CHECK;
                end
            end
            ODC_CHECK: begin
                fifo_in.valid = frame_good;
                next_dropped = frame_good && !fifo_in.ready;
                next_tog_seen = tog_s;
                next_state = ODC_IDLE;
            end
            default: begin
                next_state = ODC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= ODC_IDLE;
            tog_seen <= tog_s;
            dropped <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            tog_seen <= next_tog_seen;
            dropped <= next_dropped;
        end
    end

    assign frame_dropped = dropped;

    ////////////////////////////////////////////////////////////////////////////////
    // Command register, fault latches and status word

    odc_word_t cmd_q, next_cmd;
    odc_drv_t oc_q, next_oc, gate_q, next_gate, ol_en_q, next_ol_en, req, oc_set, ot_drv;
    logic [`ODC_PAIR_N-1:0] ot_q, next_ot;
    logic sf_q, next_sf;
    odc_pin_t cap_q, next_cap;
    logic drain_rdy, next_drain_rdy;
    logic apply, cap_evt;
    odc_word_t status_live, new_cmd;

    // Drain pauses a cycle after each word so fault clears settle before the next
    assign fifo_out.ready = drain_rdy;

    always_comb begin
        apply = fifo_out.valid && drain_rdy;
        new_cmd = fifo_out.data;
        next_drain_rdy = !apply;
        next_cmd = apply ? new_cmd : cmd_q;
        req = drive_req(cmd_q, pin_s);
        oc_set = oc_s & req;
        next_sf = sf_s | (sf_q & !apply);
        for (int i = 0; i < `ODC_DRV_N; i++) begin
            next_oc[i] = oc_set[i] | (oc_q[i] & !(apply && !new_cmd[i]));
        end
        for (int p = 0; p < `ODC_PAIR_N; p++) begin
            next_ot[p] = ot_s[p] | (ot_q[p] & !(apply && !new_cmd[2*p] && !new_cmd[2*p+1]));
            ot_drv[2*p] = ot_q[p];
            ot_drv[2*p+1] = ot_q[p];
        end
        cap_evt = |(oc_set & ~oc_q) || |(ot_s & ~ot_q);
        next_cap = cap_evt ? pin_s : cap_q;
        next_gate = drive_req(cmd_q, pin_s) & ~oc_q & ~ot_drv & {`ODC_DRV_N{!sf_s}};
        next_ol_en = cmd_q[`ODC_CMD_OL_LO +: `ODC_DRV_N];
        // Disabled enable pin holds the device idle and wipes the command and every fault latch
        if (!enable_s) begin
            next_cmd = `ODC_CMD_RESET;
            next_oc = '0;
            next_ot = '0;
            next_sf = 1'b0;
            next_gate = '0;
            next_ol_en = '0;
        end
    end

    always_comb begin
        status_live = `ODC_STATUS_RESET;
        status_live[`ODC_ST_TW] = tw_s;
        for (int i = 0; i < `ODC_DRV_N; i++) begin
            if (cmd_q[`ODC_CMD_EN_LO + i]) begin
                status_live[`ODC_ST_DRV_LO + i] = oc_q[i] | ot_drv[i];
            end else begin
                status_live[`ODC_ST_DRV_LO + i] = cmd_q[`ODC_CMD_OL_LO + i] & ol_s[i];
            end
        end
        status_live[`ODC_ST_PIN_LO +: `ODC_PIN_N] = (|oc_q || |ot_q) ? cap_q : pin_s;
        status_live[`ODC_ST_SUPPLY] = sf_q;
        // Frozen while select is low so the link shifts a stable word
        next_status_hold = cs_n_s ? status_live : status_hold;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cmd_q <= `ODC_CMD_RESET;
            oc_q <= '0;
            ot_q <= '0;
            sf_q <= 1'b0;
            cap_q <= '0;
            gate_q <= '0;
            ol_en_q <= '0;
            drain_rdy <= 1'b0;
            status_hold <= `ODC_STATUS_RESET;
        end else if (clk_en) begin
            cmd_q <= next_cmd;
            oc_q <= next_oc;
            ot_q <= next_ot;
            sf_q <= next_sf;
            cap_q <= next_cap;
            gate_q <= next_gate;
            ol_en_q <= next_ol_en;
            drain_rdy <= next_drain_rdy;
            status_hold <= next_status_hold;
        end
    end

    assign driver_gate = gate_q;
    assign open_load_enable = ol_en_q;
endmodule

// [sim/odc_spi_ctrl_chk.sv]
// Concurrent checks on the ports of the serial control block.
// Assumes the system clock domain; serial pins are seen through their levels.
`timescale 1ns/1ps
`include "odc_consts.svh"

module odc_spi_ctrl_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic serial_out_oe,
    input wire logic enable_pin,
    input wire logic supply_fault_raw,
    input wire logic [`ODC_PAIR_N-1:0] over_temp_raw,
    input wire logic [`ODC_DRV_N-1:0] over_current_raw,
    input wire logic [`ODC_DRV_N-1:0] driver_gate,
    input wire logic [`ODC_DRV_N-1:0] open_load_enable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    property p_oe; serial_out_oe == !chip_select_n; endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    property p_en; !enable_pin [*4] |-> {driver_gate, open_load_enable} == 16'h0000; endproperty
    a_en: assert property (p_en) else $error("outputs kept with enable low");
    // With the enable pin high, command only moves once a frame has closed, never mid frame
    property p_hold; (!chip_select_n && enable_pin) [*8] |-> $stable(open_load_enable); endproperty
    a_hold: assert property (p_hold) else $error("command moved in frame");
    property p_apply; $changed(open_load_enable) && enable_pin |-> $past(chip_select_n, 3);
    endproperty
    a_apply: assert property (p_apply) else $error("command applied without frame");
    property p_ot; over_temp_raw[0] [*5] |-> driver_gate[1:0] == 2'b00; endproperty
    a_ot: assert property (p_ot) else $error("pair on in shutdown");
    property p_oc; $rose(over_current_raw[0]) && driver_gate[0] |-> ##[1:5] !driver_gate[0];
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent not latched off");
    property p_oc_hold;
        $fell(driver_gate[0]) && over_current_raw[0] && enable_pin ##1 chip_select_n [*8]
            |-> !driver_gate[0];
    endproperty
    a_oc_hold: assert property (p_oc_hold) else $error("overcurrent latch lost");
    property p_supply; supply_fault_raw [*5] |-> driver_gate == 8'h00; endproperty
    a_supply: assert property (p_supply) else $error("driver on in supply fault");
endmodule

bind odc_spi_ctrl odc_spi_ctrl_chk i_odc_spi_ctrl_chk (.sys_clk(sys_clk), .reset(reset),
    .chip_select_n(chip_select_n), .serial_out_oe(serial_out_oe), .enable_pin(enable_pin),
    .supply_fault_raw(supply_fault_raw), .over_temp_raw(over_temp_raw),
    .over_current_raw(over_current_raw), .driver_gate(driver_gate),
    .open_load_enable(open_load_enable));

// [sim/odc_host_model.sv]
// Serial host model that frames words into the control block.
// Assumes the bench resolves the response line into miso.
`timescale 1ns/1ps

module odc_host_model (
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_in,
    input wire logic miso
);
    initial begin
        serial_clock = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
    end
    ////////////////////////////////////////
    // Clock runs only inside frames; any count n is allowed so bad lengths can be sent
    task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] r);
        r = 32'h0000_0000;
        chip_select_n = 1'b0;
        #200;
        for (int i = 0; i < n; i++) begin
            serial_in = d[i];
            #15 serial_clock = 1'b1;
            r[i] = miso;
            #15 serial_clock = 1'b0;
        end
        #30 chip_select_n = 1'b1;
        serial_in = ~serial_in;
        #400;
    endtask
endmodule

// [sim/odc_spi_ctrl_test.sv]
// Self-checking bench for the serial control block.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ps

module odc_spi_ctrl_test;
    logic sys_clk, reset, clk_en, enable_pin, thermal_warning_raw, supply_fault_raw;
    logic frame_dropped;
    logic [3:0] pins, over_temp_raw;
    logic [7:0] over_current_raw, open_load_raw, driver_gate, open_load_enable;
    logic serial_clock, chip_select_n, serial_in, serial_out, serial_out_oe, miso;
    logic so_last = 1'b0;
    logic [31:0] rx;
    int n_errors = 0;
    int checked = 0;
    int n_drop = 0;
    // Drain keeps pace with the host here, so no frame may ever be lost
    always @(negedge sys_clk) if (frame_dropped !== 1'b0) n_drop++;
    // Released line shows the inverse of its last value, not a lucky constant
    always @(posedge sys_clk) if (serial_out_oe) so_last <= serial_out;
    assign miso = serial_out_oe ? serial_out : ~so_last;
    odc_spi_ctrl i_odc_spi_ctrl (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .serial_clock(serial_clock), .chip_select_n(chip_select_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe), .parallel_drive_input(pins),
        .enable_pin(enable_pin), .thermal_warning_raw(thermal_warning_raw),
        .over_temp_raw(over_temp_raw), .over_current_raw(over_current_raw),
        .open_load_raw(open_load_raw), .supply_fault_raw(supply_fault_raw),
        .driver_gate(driver_gate), .open_load_enable(open_load_enable),
        .frame_dropped(frame_dropped));
    odc_host_model i_odc_host_model (.serial_clock(serial_clock),
        .chip_select_n(chip_select_n), .serial_in(serial_in), .miso(miso));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wt(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic frame(input int n, input logic [31:0] d);
        i_odc_host_model.xfer(n, d, rx);
        @(negedge sys_clk);
    endtask
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
    ////////////////////////////////////////
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        enable_pin = 1'b1;
        thermal_warning_raw = 1'b1;
        supply_fault_raw = 1'b0;
        pins = 4'hA;
        over_temp_raw = 4'h0;
        over_current_raw = 8'h00;
        open_load_raw = 8'h06;
        wt(4);
        reset = 1'b0;
        wt(4);
        frame(16, 32'h0000_0204);
        chk(rx[15:0], 16'h1401, "status");
        chk({open_load_enable, driver_gate}, 16'h02A4, "outputs");
        frame(16, 32'h0000_0000);
        chk(rx[15:0], 16'h1405, "status");
        chk({open_load_enable, driver_gate}, 16'h00A0, "outputs");
        $display("fields test done");
        frame(15, 32'h0000_00FF);
        chk({open_load_enable, driver_gate}, 16'h00A0, "outputs");
        frame(17, 32'h0001_FFFF);
        chk({open_load_enable, driver_gate}, 16'h00A0, "outputs");
        frame(32, 32'h0001_1234);
        chk(rx[31:16], 16'h1234, "chained");
        chk({open_load_enable, driver_gate}, 16'h00A1, "outputs");
        $display("length test done");
        clk_en = 1'b0;
        pins = 4'h5;
        wt(6);
        chk({open_load_enable, driver_gate}, 16'h00A1, "outputs");
        clk_en = 1'b1;
        wt(4);
        chk({open_load_enable, driver_gate}, 16'h0051, "outputs");
        over_current_raw = 8'h01;
        wt(10);
        chk({open_load_enable, driver_gate}, 16'h0050, "outputs");
        pins = 4'h0;
        wt(4);
        frame(16, 32'h0000_0001);
        chk(rx[15:0], 16'h0A03, "status");
        over_current_raw = 8'h00;
        frame(16, 32'h0000_0000);
        chk(rx[15:0], 16'h0A03, "status");
        frame(16, 32'h0000_0001);
        chk(rx[15:0], 16'h0001, "status");
        chk({open_load_enable, driver_gate}, 16'h0001, "outputs");
        $display("overcurrent test done");
        supply_fault_raw = 1'b1;
        wt(10);
        chk({open_load_enable, driver_gate}, 16'h0000, "outputs");
        frame(16, 32'h0000_0001);
        chk({15'h0000, rx[15]}, 16'h0001, "supply bit");
        supply_fault_raw = 1'b0;
        thermal_warning_raw = 1'b0;
        wt(4);
        frame(16, 32'h0000_0001);
        chk({15'h0000, rx[15]}, 16'h0001, "supply bit");
        frame(16, 32'h0000_0001);
        chk(rx[15:0], 16'h0000, "status");
        $display("supply test done");
        over_temp_raw = 4'h1;
        wt(10);
        chk({open_load_enable, driver_gate}, 16'h0000, "outputs");
        over_temp_raw = 4'h0;
        wt(4);
        chk({open_load_enable, driver_gate}, 16'h0000, "outputs");
        enable_pin = 1'b0;
        wt(10);
        enable_pin = 1'b1;
        wt(4);
        chk({open_load_enable, driver_gate}, 16'h0000, "outputs");
        frame(16, 32'h0000_0001);
        chk({open_load_enable, driver_gate}, 16'h0001, "outputs");
        $display("shutdown test done");
        chk(16'(n_drop), 16'h0000, "dropped frames");
        print_verdict();
    end
endmodule
